// ### core/gpplm_pkg.sv
package gpplm_pkg;
    localparam int PIN_W  = 4;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] LCD_LATCH_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] LCD_DIR_OFS   = 3'h1;
    localparam logic [ADDR_W-1:0] TMR_LATCH_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] TMR_DIR_OFS   = 3'h3;
    localparam logic [ADDR_W-1:0] TMR_PUL_OFS   = 3'h4;
    localparam logic [ADDR_W-1:0] CTRL_OFS      = 3'h5;

    // control register fields
    localparam int CTRL_SPL_BIT   = 0;
    localparam int CTRL_LCD_PORT_INPUT_CONTROL_BIT = 1;
    localparam int CTRL_SEL_LSB   = 4;

    // reset values
    localparam logic [PIN_W-1:0]  LATCH_RST = 4'h0;
    localparam logic [PIN_W-1:0]  DIR_RST   = 4'h0;
    localparam logic [PIN_W-1:0]  PUL_RST   = 4'h0;
    localparam logic [PIN_W-1:0]  SEL_RST   = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
        logic              read_modify_write_access;
    } gpplm_bus_req_type;

    typedef struct packed {
        logic [PIN_W-1:0] out;
        logic [PIN_W-1:0] oe_n;
    } gpplm_pin_drv_type;
endpackage : gpplm_pkg

// ### core/gpplm_port.sv
// Operation
// - direction one drives latch onto pin
// - direction zero leaves pin undriven input
// - data write always updates latch
// - output pin reads return latch
// - input pin reads pin, rmw reads latch
// - peripheral output enable overrides port latch
// - peripheral-driven pin reads pin level, rmw latch
// - peripheral input gets pin level, direction zero
// - reset clears every direction bit
// - standby with control one forces hi-z
// - standby with control zero keeps states
// - pull-up bit one connects pull-up
// - driven-low pin disconnects pull-up
// - bits three to zero map pins
// - timer port has pull-up register
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module gpplm_port (
    input  wire logic                        clk_sys_i,
    input  wire logic                        sys_rst_i,
    input  wire gpplm_pkg::gpplm_bus_req_type bus_req_i,
    output logic [gpplm_pkg::DATA_W-1:0]     rdata_o,
    input  wire logic                        standby_entry_i,
    input  wire logic [gpplm_pkg::PIN_W-1:0] tmr_pin_i,
    input  wire logic [gpplm_pkg::PIN_W-1:0] tmr_periph_out_i,
    input  wire logic [gpplm_pkg::PIN_W-1:0] tmr_periph_oe_i,
    output gpplm_pkg::gpplm_pin_drv_type     tmr_pin_o,
    output logic [gpplm_pkg::PIN_W-1:0]      tmr_pullup_o,
    output logic [gpplm_pkg::PIN_W-1:0]      tmr_periph_in_o,
    input  wire logic [gpplm_pkg::PIN_W-1:0] lcd_pin_i,
    input  wire logic [gpplm_pkg::PIN_W-1:0] lcd_drive_line_i,
    output gpplm_pkg::gpplm_pin_drv_type     lcd_pin_o
);
    import gpplm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [PIN_W-1:0]  tmr_latch_r;
    logic [PIN_W-1:0]  tmr_dir_r;
    logic [PIN_W-1:0]  tmr_pul_r;
    logic [PIN_W-1:0]  lcd_latch_r;
    logic [PIN_W-1:0]  lcd_dir_r;
    logic [PIN_W-1:0]  lcd_sel_r;
    logic              spl_r;
    logic              lcd_port_input_control_r;

    logic              wr_tmr_latch;
    logic              wr_tmr_dir;
    logic              wr_tmr_pul;
    logic              wr_lcd_latch;
    logic              wr_lcd_dir;
    logic              wr_ctrl;
    logic              hiz;
    logic [PIN_W-1:0]  tmr_in_g;
    logic [PIN_W-1:0]  lcd_in_g;
    logic [PIN_W-1:0]  tmr_rd_bits;
    logic [PIN_W-1:0]  lcd_rd_bits;
    logic [PIN_W-1:0]  tmr_oe;
    logic [PIN_W-1:0]  tmr_out_nxt;
    logic [PIN_W-1:0]  tmr_pul_nxt;
    logic [PIN_W-1:0]  lcd_oe;
    logic [PIN_W-1:0]  lcd_out_nxt;
    logic [DATA_W-1:0] ctrl_rd;
    logic [DATA_W-1:0] rdata_nxt;

    ////////////////////////////////////////////////////////////////////////
    // register write decode
    assign wr_tmr_latch = bus_req_i.wr && bus_req_i.addr == TMR_LATCH_OFS;
    assign wr_tmr_dir   = bus_req_i.wr && bus_req_i.addr == TMR_DIR_OFS;
    assign wr_tmr_pul   = bus_req_i.wr && bus_req_i.addr == TMR_PUL_OFS;
    assign wr_lcd_latch = bus_req_i.wr && bus_req_i.addr == LCD_LATCH_OFS;
    assign wr_lcd_dir   = bus_req_i.wr && bus_req_i.addr == LCD_DIR_OFS;
    assign wr_ctrl      = bus_req_i.wr && bus_req_i.addr == CTRL_OFS;

    assign hiz = standby_entry_i & spl_r;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tmr_dir_r <= DIR_RST;
            lcd_dir_r <= DIR_RST;
        end else begin
            if (wr_tmr_dir) tmr_dir_r <= bus_req_i.wdata[PIN_W-1:0];
            if (wr_lcd_dir) lcd_dir_r <= bus_req_i.wdata[PIN_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tmr_latch_r <= LATCH_RST;
            lcd_latch_r <= LATCH_RST;
        end else begin
            if (wr_tmr_latch) tmr_latch_r <= bus_req_i.wdata[PIN_W-1:0];
            if (wr_lcd_latch) lcd_latch_r <= bus_req_i.wdata[PIN_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tmr_pul_r <= PUL_RST;
        end else if (wr_tmr_pul) begin
            tmr_pul_r <= bus_req_i.wdata[PIN_W-1:0];
        end
    end

    // standby pin state, lcd input control, pin-function select
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            spl_r     <= 1'b0;
            lcd_port_input_control_r   <= 1'b0;
            lcd_sel_r <= SEL_RST;
        end else if (wr_ctrl) begin
            spl_r     <= bus_req_i.wdata[CTRL_SPL_BIT];
            lcd_port_input_control_r   <= bus_req_i.wdata[CTRL_LCD_PORT_INPUT_CONTROL_BIT];
            lcd_sel_r <= bus_req_i.wdata[CTRL_SEL_LSB +: PIN_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-pin muxing, one slice per bit
    // bit n maps to pin n
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin
            assign tmr_oe[gi]      = ~hiz &
                                     (tmr_periph_oe_i[gi] | tmr_dir_r[gi]);
            assign tmr_out_nxt[gi] = tmr_periph_oe_i[gi] ?
                                     tmr_periph_out_i[gi] : tmr_latch_r[gi];
            assign tmr_pul_nxt[gi] = tmr_pul_r[gi] &
                                     ~(tmr_oe[gi] & ~tmr_out_nxt[gi]);
            assign tmr_in_g[gi]    = tmr_pin_i[gi] & ~hiz;
            // rmw and output pins not taken by the peripheral read latch
            assign tmr_rd_bits[gi] = (bus_req_i.read_modify_write_access ||
                                      (tmr_dir_r[gi] && !tmr_periph_oe_i[gi]))
                                     ? tmr_latch_r[gi] : tmr_in_g[gi];
            // selected lcd pins drive only once input control is set
            assign lcd_oe[gi]      = ~hiz & (lcd_sel_r[gi] ? lcd_port_input_control_r
                                                           : lcd_dir_r[gi]);
            assign lcd_out_nxt[gi] = lcd_sel_r[gi] ?
                                     lcd_drive_line_i[gi] : lcd_latch_r[gi];
            // no pull-up on lcd port; input gated as timer port
            assign lcd_in_g[gi]    = lcd_pin_i[gi] & ~hiz;
            assign lcd_rd_bits[gi] = (bus_req_i.read_modify_write_access || lcd_dir_r[gi])
                                     ? lcd_latch_r[gi] : lcd_in_g[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    assign ctrl_rd = {lcd_sel_r, 2'b00, lcd_port_input_control_r, spl_r};

    // unmapped offsets fall through to zero
    // read select, upper bits zero except control
    assign rdata_nxt =
        !bus_req_i.rd                   ? RDATA_RST :
        bus_req_i.addr == TMR_LATCH_OFS ? {4'h0, tmr_rd_bits} :
        bus_req_i.addr == TMR_DIR_OFS   ? {4'h0, tmr_dir_r} :
        bus_req_i.addr == TMR_PUL_OFS   ? {4'h0, tmr_pul_r} :
        bus_req_i.addr == LCD_LATCH_OFS ? {4'h0, lcd_rd_bits} :
        bus_req_i.addr == LCD_DIR_OFS   ? {4'h0, lcd_dir_r} :
        bus_req_i.addr == CTRL_OFS      ? ctrl_rd : RDATA_RST;

    // pins are registered so every output is glitch free
    // drive latch onto output pins
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o         <= RDATA_RST;
            tmr_pin_o       <= '{out: LATCH_RST, oe_n: 4'hf};
            lcd_pin_o       <= '{out: LATCH_RST, oe_n: 4'hf};
            tmr_pullup_o    <= PUL_RST;
            tmr_periph_in_o <= 4'h0;
        end else begin
            rdata_o         <= rdata_nxt;
            tmr_pin_o       <= '{out: tmr_out_nxt, oe_n: ~tmr_oe};
            lcd_pin_o       <= '{out: lcd_out_nxt, oe_n: ~lcd_oe};
            tmr_pullup_o    <= tmr_pul_nxt;
            tmr_periph_in_o <= tmr_in_g;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins are checked one cycle after their cause
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    a_port_drive_latch: assert property (
        !hiz && tmr_periph_oe_i == 4'h0 |=>
        tmr_pin_o.oe_n == ~$past(tmr_dir_r) &&
        ((tmr_pin_o.out ^ $past(tmr_latch_r)) & $past(tmr_dir_r)) == 4'h0)
        else $error("output pin does not carry latch");

    a_input_undriven: assert property (
        1'b1 |=>
        (~tmr_pin_o.oe_n & ~$past(tmr_dir_r | tmr_periph_oe_i)) == 4'h0)
        else $error("input pin is driven");

    a_latch_write_any: assert property (
        wr_tmr_latch ##1 !wr_tmr_latch[*2] |->
        tmr_latch_r == $past(bus_req_i.wdata[PIN_W-1:0], 2))
        else $error("latch write lost");

    a_rmw_read_latch: assert property (
        bus_req_i.rd && bus_req_i.read_modify_write_access &&
        bus_req_i.addr == TMR_LATCH_OFS |=>
        rdata_o == {4'h0, $past(tmr_latch_r)})
        else $error("rmw read did not return latch");

    a_input_read_pin: assert property (
        bus_req_i.rd && !bus_req_i.read_modify_write_access && !hiz &&
        bus_req_i.addr == TMR_LATCH_OFS &&
        (tmr_dir_r & ~tmr_periph_oe_i) == 4'h0 |=>
        rdata_o[PIN_W-1:0] == $past(tmr_pin_i))
        else $error("normal read did not return pin");

    a_periph_drives: assert property (
        !hiz && tmr_periph_oe_i == 4'hf |=>
        tmr_pin_o.oe_n == 4'h0 && tmr_pin_o.out == $past(tmr_periph_out_i))
        else $error("peripheral output not on pin");

    a_reset_dir_zero: assert property (
        @(posedge clk_sys_i) disable iff (1'b0)
        $fell(sys_rst_i) |-> tmr_dir_r == 4'h0 && lcd_dir_r == 4'h0)
        else $error("direction not cleared by reset");

    a_standby_hiz: assert property (
        hiz |=> tmr_pin_o.oe_n == 4'hf && lcd_pin_o.oe_n == 4'hf &&
        tmr_periph_in_o == 4'h0)
        else $error("standby did not force hi-z");

    a_standby_keep: assert property (
        standby_entry_i && !spl_r && tmr_periph_oe_i == 4'h0 |=>
        tmr_pin_o.oe_n == ~$past(tmr_dir_r))
        else $error("standby changed pin state");

    a_pullup_low_off: assert property (
        (~tmr_pin_o.oe_n & ~tmr_pin_o.out & tmr_pullup_o) == 4'h0)
        else $error("pull-up on a pin driven low");

    a_upper_bits_zero: assert property (
        bus_req_i.rd && bus_req_i.addr != CTRL_OFS |=>
        rdata_o[DATA_W-1:PIN_W] == 4'h0)
        else $error("unused upper bits not zero");

    a_read_idle_zero: assert property (
        !bus_req_i.rd |=> rdata_o == RDATA_RST)
        else $error("read data present without a read");

    a_output_read_latch: assert property (
        bus_req_i.rd && bus_req_i.addr == TMR_LATCH_OFS |=>
        ((rdata_o[PIN_W-1:0] ^ $past(tmr_latch_r)) &
         $past(tmr_dir_r & ~tmr_periph_oe_i)) == 4'h0)
        else $error("output pin read did not return latch");

    a_lcd_rmw_latch: assert property (
        bus_req_i.rd && bus_req_i.read_modify_write_access &&
        bus_req_i.addr == LCD_LATCH_OFS |=>
        rdata_o == {4'h0, $past(lcd_latch_r)})
        else $error("lcd rmw read did not return latch");

    a_periph_in_pin: assert property (
        !hiz |=> tmr_periph_in_o == $past(tmr_pin_i))
        else $error("peripheral input differs from pin");

    a_pullup_follows: assert property (
        1'b1 |=>
        (tmr_pin_o.oe_n & (tmr_pullup_o ^ $past(tmr_pul_r))) == 4'h0)
        else $error("pull-up of undriven pin differs from its bit");

    a_lcd_line_drive: assert property (
        !hiz && lcd_port_input_control_r |=>
        (lcd_pin_o.oe_n & $past(lcd_sel_r)) == 4'h0 &&
        ((lcd_pin_o.out ^ $past(lcd_drive_line_i)) &
         $past(lcd_sel_r)) == 4'h0)
        else $error("lcd drive line not on pin");

    a_hiz_read_low: assert property (
        hiz && bus_req_i.rd && !bus_req_i.read_modify_write_access &&
        bus_req_i.addr == TMR_LATCH_OFS |=>
        (rdata_o[PIN_W-1:0] &
         ~$past(tmr_dir_r & ~tmr_periph_oe_i)) == 4'h0)
        else $error("input path not held low in standby");

    a_lcd_port_drive: assert property (
        !hiz |=>
        ((lcd_pin_o.out ^ $past(lcd_latch_r)) &
         $past(lcd_dir_r & ~lcd_sel_r)) == 4'h0)
        else $error("lcd output pin does not carry latch");

    // main scenarios
    c_output_mode: cover property (wr_tmr_dir ##[1:12] wr_tmr_latch);
    c_rmw_read:    cover property (bus_req_i.rd && bus_req_i.read_modify_write_access);
    c_standby_hiz: cover property (standby_entry_i && spl_r);
    c_lcd_drive:   cover property (lcd_sel_r != 4'h0 && lcd_port_input_control_r);
    c_periph_read: cover property (bus_req_i.rd && !bus_req_i.read_modify_write_access &&
                                   tmr_periph_oe_i != 4'h0);
endmodule : gpplm_port

// ### verification/gpplm_pin_model.sv
`timescale 1ns/1ps
module gpplm_pin_model (
    input  wire gpplm_pkg::gpplm_pin_drv_type drv_i,
    input  wire logic [gpplm_pkg::PIN_W-1:0]  pullup_i,
    input  wire logic [gpplm_pkg::PIN_W-1:0]  ext_i,
    output logic [gpplm_pkg::PIN_W-1:0]       pin_o
);
    import gpplm_pkg::*;
    // connected pull-up wins over the outside circuit
    assign pin_o = (~drv_i.oe_n & drv_i.out) |
                   (drv_i.oe_n & (pullup_i | ext_i));
endmodule : gpplm_pin_model

// ### verification/gpplm_port_tb.sv
`timescale 1ns/1ps
module gpplm_port_tb;
    import gpplm_pkg::*;
    logic              clk_sys_i, sys_rst_i, standby, st, read_modify_write_access, hiz;
    gpplm_bus_req_type req;
    gpplm_pin_drv_type tdrv, ldrv;
    logic [7:0]        rdata, exp_rd, ctl, v;
    logic [2:0]        a;
    logic [3:0]        tpin, pout, poe, tpul, tp_in, lpin, lline, tex, lex;
    logic [3:0]        lat_t, dir_t, pul_t, lat_l, dir_l, po, pe, ll, te, le;
    logic [3:0]        t_drv, t_out, t_lvl, l_drv, l_out, l_lvl, sel;
    logic [3:0]        t_oen, l_oen;
    logic [31:0]       seed;
    int                miscompares, n_compared, cycles;

    gpplm_port dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .bus_req_i(req), .rdata_o(rdata), .standby_entry_i(standby),
        .tmr_pin_i(tpin), .tmr_periph_out_i(pout), .tmr_periph_oe_i(poe),
        .tmr_pin_o(tdrv), .tmr_pullup_o(tpul), .tmr_periph_in_o(tp_in),
        .lcd_pin_i(lpin), .lcd_drive_line_i(lline), .lcd_pin_o(ldrv));
    gpplm_pin_model tmr_u (.drv_i(tdrv), .pullup_i(tpul), .ext_i(tex),
        .pin_o(tpin));
    gpplm_pin_model lcd_u (.drv_i(ldrv), .pullup_i(4'h0), .ext_i(lex),
        .pin_o(lpin));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles > 12000) begin
            miscompares++;
            end_of_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction : xs

    // one bus cycle; staged pin-side values land on the same edge
    task cyc(input logic w, input logic r);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: v, wr: w, rd: r, read_modify_write_access: read_modify_write_access};
        {standby, pout, poe, lline, tex, lex} <= {st, po, pe, ll, te, le};
        @(negedge clk_sys_i);
        chk("rdata", exp_rd, rdata);
        exp_rd = 8'h00;
    endtask : cyc

    task do_reset;
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        {lat_t, dir_t, pul_t, lat_l, dir_l} = '0;
        ctl = 8'h00;
    endtask : do_reset

    // levels gated to 0 while standby forces hi-z
    task model;
        hiz = st & ctl[0];
        t_drv = hiz ? 4'h0 : (dir_t | pe);
        t_oen = ~t_drv;
        t_out = (pe & po) | (~pe & lat_t);
        t_lvl = hiz ? 4'h0 : ((t_drv & t_out) | (~t_drv & (pul_t | te)));
        l_drv = hiz ? 4'h0 : (ctl[7:4] | dir_l);
        l_oen = ~l_drv;
        l_out = (ctl[7:4] & ll) | (~ctl[7:4] & lat_l);
        l_lvl = hiz ? 4'h0 : ((l_drv & l_out) | (~l_drv & le));
        sel = read_modify_write_access ? 4'hf : (dir_t & ~pe);
    endtask : model
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst_i = 1'b1;
        req = '0;
        {standby, pout, poe, lline, tex, lex} = '0;
        {st, po, pe, ll, te, le, read_modify_write_access, a, v, exp_rd} = '0;
        seed = 32'hbe39_b2c1;
        do_reset;
        for (int i = 0; i < 1500; i++) begin
            if (i == 700)
                do_reset;
            seed = xs(seed);
            {st, po, ll, te, le} = {&seed[1:0], seed[18:3]};
            // peripheral outputs off for half the runs
            pe = seed[22:19] & {4{seed[23]}};
            seed = xs(seed);
            {a, v} = seed[10:0];
            // lcd select with input control set
            if (a == CTRL_OFS)
                v = {v[7:4] & ~dir_l, 4'h2 | (v[3:0] & 4'h1)};
            if (a == LCD_DIR_OFS)
                v[3:0] = v[3:0] & ~ctl[7:4];
            cyc(1'b1, 1'b0);
            case (a)
                3'h0: lat_l = v[3:0];
                3'h1: dir_l = v[3:0];
                3'h2: lat_t = v[3:0];
                3'h3: dir_t = v[3:0];
                3'h4: pul_t = v[3:0];
                3'h5: ctl = v;
                default: ;
            endcase
            repeat (3) cyc(1'b0, 1'b0);
            seed = xs(seed);
            {read_modify_write_access, a} = seed[3:0];
            cyc(1'b0, 1'b1);
            model;
            case (a)
                3'h0: exp_rd = {4'h0, read_modify_write_access ? lat_l :
                                (dir_l & lat_l) | (~dir_l & l_lvl)};
                3'h1: exp_rd = {4'h0, dir_l};
                3'h2: exp_rd = {4'h0, (sel & lat_t) | (~sel & t_lvl)};
                3'h3: exp_rd = {4'h0, dir_t};
                3'h4: exp_rd = {4'h0, pul_t};
                3'h5: exp_rd = ctl;
                default: exp_rd = 8'h00;
            endcase
            cyc(1'b0, 1'b0);
            chk("tmr_oe_n", t_oen, tdrv.oe_n);
            chk("tmr_out", t_drv & t_out, t_drv & tdrv.out);
            chk("tmr_pullup", pul_t & ~(t_drv & ~t_out), tpul);
            chk("periph_in", t_lvl, tp_in);
            chk("lcd_oe_n", l_oen, ldrv.oe_n);
            chk("lcd_out", l_drv & l_out, l_drv & ldrv.out);
        end
        end_of_test;
    end
endmodule : gpplm_port_tb
